//--- hdl/vdb_top.sv
// Video decoder back-end control: registers, enhancement, write-back.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module vdb_top
  (input  wire logic                 CLK_SYS_IN,
   input  wire logic                 RST_IN,
   input  wire logic                 HSEL_IN,
   input  wire logic [31:0]          HADDR_IN,
   input  wire logic [1:0]           HTRANS_IN,
   input  wire logic                 HWRITE_IN,
   input  wire logic [2:0]           HSIZE_IN,
   input  wire logic [31:0]          HWDATA_IN,
   input  wire logic                 HREADY_IN,
   output logic      [31:0]          HRDATA_OUT,
   output logic                      HREADYOUT_OUT,
   output logic                      HRESP_OUT,
   input  wire vdb_pkg::vdb_pix_in_s PIX_IN,
   output vdb_pkg::vdb_pix_out_s     PIX_OUT,
   input  wire logic                 LOCK_IN,
   input  wire logic [7:0]           FIFO_FAULT_IN,
   input  wire logic [7:0]           AUTO_GAIN_IN,
   input  wire logic                 FIELD_START_IN,
   input  wire logic                 FIELD_ID_IN,
   input  wire logic                 LINE_END_IN,
   output vdb_pkg::vdb_ctl_s         CTL_OUT,
   output logic                      WB_ACTIVE_OUT,
   output logic      [31:0]          WB_LUMA_ADDR_OUT,
   output logic      [31:0]          WB_CHROMA_ADDR_OUT,
   output logic      [11:0]          WB_LINE_PIXELS_OUT,
   output logic                      IRQ_OUT);
   import vdb_pkg::*;

   typedef logic [7:0] vdb_byte_t;

   typedef struct packed {
      logic [31:0]       ycs1, ycs2, enh1, enh2, cgain, wbctl, wbgeo;
      logic [31:0]       ybase, cbase, ien, iflag, dbg;
      logic              ap_wr;
      logic [ADDR_W-1:0] ap_addr;
      logic [31:0]       rdata;
      logic              lock_seen;
      logic              kick_up, kick_dn;
      vdb_byte_t [SKEW_DEPTH-1:0] ydly, cdly;
      logic [SKEW_DEPTH-1:0]      vdly;
      vdb_wb_e           wb;
      logic              field;
      logic [10:0]       line;
      logic [31:0]       yaddr, caddr;
   } vdb_state_s;

   vdb_state_s st, next_st;

   // Skew selection, shared by the datapath and the assertions.
   logic [2:0] luma_tap, chroma_tap;
   logic [3:0] skew;

   function automatic vdb_byte_t sat8(input logic signed [19:0] v);
      if (v < 0)
         sat8 = 8'h00;
      else if (v > 20'sd255)
         sat8 = 8'hff;
      else
         sat8 = v[7:0];
   endfunction : sat8

   function automatic vdb_byte_t enhance_luma(input logic [7:0] y,
                                              input logic signed [8:0] hp,
                                              input logic [31:0] e1);
      logic signed [19:0] acc;
      logic signed [19:0] sh;
      acc = $signed({12'h000, y});
      sh  = 20'sh00000;
      // A zero denominator would divide by zero, so it leaves luma unsharpened.
      if (e1[B_SHARP_ON] && e1[29:28] != 2'h0)
         sh = (20'(hp) * $signed({17'h00000, e1[27:25]}))
              / $signed({18'h00000, e1[29:28]});
      acc = acc + sh;
      acc = acc + $signed({11'h000, e1[23:16]})
                - $signed({11'h000, BRIGHT_ZERO});
      if (acc < 0)
         acc = 20'sh00000;
      acc = (acc * $signed({12'h000, e1[15:8]})) >>> UNITY_SHIFT;
      enhance_luma = sat8(acc);
   endfunction : enhance_luma

   function automatic vdb_byte_t enhance_chroma(input logic [7:0] c,
                                                input logic [7:0] g);
      logic signed [19:0] d;
      // Gain applies around the chroma zero level, not around code zero.
      d = $signed({12'h000, c}) - 20'sd128;
      d = (d * $signed({12'h000, g})) >>> UNITY_SHIFT;
      enhance_chroma = sat8(d + 20'sd128);
   endfunction : enhance_chroma

   always_comb
   begin
      skew = st.enh1[3:0];
      luma_tap   = 3'h0;
      chroma_tap = 3'h0;
      // Reserved codes fall back to no skew rather than an arbitrary one.
      if (skew >= 4'h3 && skew <= 4'h7)
         luma_tap = skew[2:0];
      else if (skew >= 4'hb)
         chroma_tap = 3'(5'h10 - {1'b0, skew});
   end

   logic        wr_now, rd_now, clr_base_err;
   logic [31:0] wmask, set_flags;
   logic [10:0] lines_next;
   logic [31:0] line_step;
   logic        take_field, eff_field, lock_now;

   always_comb
   begin
      next_st = st;
      set_flags = 32'h00000000;
      wr_now = st.ap_wr;
      rd_now = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;
      wmask = HWDATA_IN;
      clr_base_err = 1'b0;
      lock_now = LOCK_IN;
      eff_field = FIELD_ID_IN ^ st.wbctl[B_FLIP];
      take_field = st.wbctl[B_FRAME] || (eff_field == st.wbctl[B_FSEL]);
      line_step = st.wbctl[B_FRAME] ? {4'h0, st.wbctl[27:16], 16'h0000} >> 15
                                    : {20'h00000, st.wbctl[27:16]};
      lines_next = st.line + 11'h001;
      // Address phase capture; only writes need the data phase.
      next_st.ap_wr = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN;
      next_st.ap_addr = HADDR_IN[ADDR_W-1:0];
      next_st.kick_up = 1'b0;
      next_st.kick_dn = 1'b0;
      if (wr_now)
      begin
         case (st.ap_addr)
            OFS_YCS1:  next_st.ycs1  = HWDATA_IN & MSK_YCS1;
            OFS_YCS2:  next_st.ycs2  = HWDATA_IN;
            OFS_ENH1:  next_st.enh1  = HWDATA_IN & MSK_ENH1;
            OFS_ENH2:  next_st.enh2  = HWDATA_IN & MSK_ENH2;
            OFS_CGAIN: next_st.cgain = HWDATA_IN & MSK_CGAIN;
            OFS_WBCTL: next_st.wbctl = HWDATA_IN & MSK_WBCTL;
            OFS_WBGEO: next_st.wbgeo = HWDATA_IN & MSK_WBGEO;
            OFS_YBASE:
            begin
               next_st.ybase = HWDATA_IN;
               clr_base_err = 1'b1;
            end
            OFS_CBASE:
            begin
               next_st.cbase = HWDATA_IN;
               clr_base_err = 1'b1;
            end
            OFS_IEN:   next_st.ien   = HWDATA_IN & MSK_IEN;
            OFS_DBG:
            begin
               // Kicks are one-shot; they count only in software clamp mode.
               next_st.dbg = HWDATA_IN & MSK_DBG & ~(32'h3 << B_RAISE);
               next_st.kick_up = HWDATA_IN[B_CLMODE] && HWDATA_IN[B_RAISE];
               next_st.kick_dn = HWDATA_IN[B_CLMODE] && HWDATA_IN[B_LOWER];
            end
            default: ;
         endcase
      end
      // Decoder lock edges.
      next_st.lock_seen = lock_now;
      set_flags[F_LOCK]   = lock_now && !st.lock_seen;
      set_flags[F_UNLOCK] = !lock_now && st.lock_seen;
      set_flags[31:28] = FIFO_FAULT_IN[7:4];
      set_flags[8:7]   = FIFO_FAULT_IN[3:2];
      set_flags[5:4]   = FIFO_FAULT_IN[1:0];
      // Moving a base while lines are being written corrupts the buffer.
      set_flags[F_BASEERR] = clr_base_err && st.wb == WB_LINES;
      // Write-back sequencing.
      case (st.wb)
         WB_IDLE:
            if (st.wbctl[B_STORE] && st.wbctl[B_VALID])
               next_st.wb = WB_WAIT;
         WB_WAIT:
            if (FIELD_START_IN && take_field)
            begin
               next_st.wb = WB_LINES;
               next_st.field = eff_field;
               next_st.line = 11'h000;
               next_st.yaddr = st.ybase;
               next_st.caddr = st.cbase;
               if (st.wbctl[B_FRAME] && eff_field)
               begin
                  next_st.yaddr = st.ybase + {20'h00000, st.wbctl[27:16]};
                  next_st.caddr = st.cbase + {20'h00000, st.wbctl[27:16]};
               end
            end
         WB_LINES:
            if (LINE_END_IN)
            begin
               next_st.line = lines_next;
               next_st.yaddr = st.yaddr + line_step;
               // 4:2:0 keeps every second chroma line.
               if (st.wbctl[B_FMT] || st.line[0])
                  next_st.caddr = st.caddr + line_step;
               if (lines_next >= st.wbgeo[26:16])
               begin
                  next_st.wb = WB_WAIT;
                  set_flags[F_FEND] = !st.wbctl[B_FRAME] || st.field;
               end
            end
         default: next_st.wb = WB_IDLE;
      endcase
      if (!(st.wbctl[B_STORE] && st.wbctl[B_VALID]))
         next_st.wb = WB_IDLE;
      // Flags written with one clear, but a same-cycle event wins.
      if (wr_now && st.ap_addr == OFS_IFLAG)
         next_st.iflag = st.iflag & ~HWDATA_IN;
      next_st.iflag = (next_st.iflag | set_flags) & MSK_IFLAG;
      // Pixel pipeline: enhance, then skew.
      next_st.ydly[0] = enhance_luma(PIX_IN.luma, PIX_IN.hipass, st.enh1);
      next_st.cdly[0] = enhance_chroma(PIX_IN.chroma, st.enh2[7:0]);
      next_st.vdly[0] = PIX_IN.valid;
      for (int i = 1; i < SKEW_DEPTH; i++)
      begin
         next_st.ydly[i] = st.ydly[i-1];
         next_st.cdly[i] = st.cdly[i-1];
         next_st.vdly[i] = st.vdly[i-1];
      end
      // Read data is prepared in the address phase and shown in the data phase.
      next_st.rdata = 32'h00000000;
      if (rd_now)
      begin
         case (HADDR_IN[ADDR_W-1:0])
            OFS_YCS1:  next_st.rdata = st.ycs1;
            OFS_YCS2:  next_st.rdata = st.ycs2;
            OFS_ENH1:  next_st.rdata = st.enh1;
            OFS_ENH2:  next_st.rdata = st.enh2;
            OFS_CGAIN: next_st.rdata = st.cgain;
            OFS_WBCTL: next_st.rdata = st.wbctl;
            OFS_WBGEO: next_st.rdata = st.wbgeo;
            OFS_YBASE: next_st.rdata = st.ybase;
            OFS_CBASE: next_st.rdata = st.cbase;
            OFS_IEN:   next_st.rdata = st.ien;
            OFS_IFLAG: next_st.rdata = st.iflag;
            OFS_DBG:   next_st.rdata = st.dbg;
            default:   next_st.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         st <= '0;
         st.ycs1  <= RST_YCS1;
         st.ycs2  <= RST_YCS2;
         st.enh1  <= RST_ENH1;
         st.enh2  <= RST_ENH2;
         st.cgain <= RST_CGAIN;
         st.wbctl <= RST_WBCTL;
         st.wbgeo <= RST_WBGEO;
         st.ybase <= RST_ZERO;
         st.cbase <= RST_ZERO;
         st.ien   <= RST_ZERO;
         st.iflag <= RST_ZERO;
         st.dbg   <= RST_DBG;
         st.wb    <= WB_IDLE;
      end
      else
         st <= next_st;
   end

   assign HRDATA_OUT    = st.rdata;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT     = 1'b0;
   assign PIX_OUT.luma   = st.ydly[luma_tap];
   assign PIX_OUT.chroma = st.cdly[chroma_tap];
   assign PIX_OUT.valid  = st.vdly[luma_tap > chroma_tap ? luma_tap
                                                         : chroma_tap];
   assign CTL_OUT.temporal_comb_active = !st.ycs1[B_COMB_OFF]
                                         && st.ycs1[2:0] != 3'h0;
   assign CTL_OUT.comb_separation_select = st.ycs1[2:0];
   assign CTL_OUT.chroma_order = st.wbctl[B_ORDER];
   assign CTL_OUT.subsample_filter_on = st.wbctl[B_FILT]
                                        && !st.wbctl[B_FMT];
   assign CTL_OUT.tiled_layout_select = st.wbctl[B_TILED];
   assign CTL_OUT.output_sampling_format = st.wbctl[B_FMT];
   assign CTL_OUT.clamp_auto = !st.dbg[B_CLMODE];
   assign CTL_OUT.clamp_raise_kick = st.kick_up;
   assign CTL_OUT.clamp_lower_kick = st.kick_dn;
   assign CTL_OUT.clamp_step_cycles = st.dbg[31:25];
   assign CTL_OUT.front_gain = st.dbg[B_GMODE] ? st.dbg[15:8]
                                               : AUTO_GAIN_IN;
   assign WB_ACTIVE_OUT = st.wb == WB_LINES;
   assign WB_LUMA_ADDR_OUT = st.yaddr;
   assign WB_CHROMA_ADDR_OUT = st.caddr;
   assign WB_LINE_PIXELS_OUT = st.wbgeo[11:0];
   assign IRQ_OUT = |(st.iflag & st.ien);

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);

   a_lock_rise_flag: assert property ($rose(LOCK_IN) |=> st.iflag[F_LOCK])
      else $error("lock edge did not set the lock flag");
   a_unlock_flag: assert property ($fell(LOCK_IN) |=> st.iflag[F_UNLOCK])
      else $error("unlock edge did not set the unlock flag");
   a_fault_sticky: assert property (st.iflag[4] && !(wr_now
         && st.ap_addr == OFS_IFLAG && HWDATA_IN[4]) |=> st.iflag[4])
      else $error("fifo fault flag dropped without a clear");
   a_set_beats_clear: assert property (FIFO_FAULT_IN[0] |=> st.iflag[4])
      else $error("fifo fault lost against a clear");
   a_irq_gating: assert property (IRQ_OUT == |(st.iflag & st.ien))
      else $error("interrupt output disagrees with flags and enables");
   a_idle_invalid: assert property (!st.wbctl[B_VALID] |=> !WB_ACTIVE_OUT)
      else $error("write-back ran with bases marked invalid");
   a_frame_end_flag: assert property (WB_ACTIVE_OUT && LINE_END_IN
         && lines_next >= st.wbgeo[26:16] && !st.wbctl[B_FRAME]
         |=> st.iflag[F_FEND] && !WB_ACTIVE_OUT)
      else $error("field end did not raise the frame-end flag");
   a_line_stride: assert property (WB_ACTIVE_OUT && LINE_END_IN
         && !st.wbctl[B_FRAME] && !wr_now
         |=> WB_LUMA_ADDR_OUT == $past(WB_LUMA_ADDR_OUT)
             + {20'h00000, st.wbctl[27:16]})
      else $error("luma address did not advance by the stride");
   a_gain_override: assert property (st.dbg[B_GMODE]
         |-> CTL_OUT.front_gain == st.dbg[15:8])
      else $error("programmed gain not applied in debug gain mode");
   a_comb_bypass: assert property (st.ycs1[B_COMB_OFF]
         |-> !CTL_OUT.temporal_comb_active)
      else $error("temporal comb used while disabled");
   a_base_fault: assert property (wr_now && st.ap_addr == OFS_YBASE
         && WB_ACTIVE_OUT |=> st.iflag[F_BASEERR])
      else $error("base change during write-back not flagged");
   a_skew_luma: assert property (skew == 4'h5 |-> luma_tap == 3'h5
         && chroma_tap == 3'h0)
      else $error("luma skew tap wrong");
   a_clamp_kick: assert property (wr_now && st.ap_addr == OFS_DBG
         && HWDATA_IN[B_CLMODE] && HWDATA_IN[B_RAISE]
         |=> CTL_OUT.clamp_raise_kick ##1 !CTL_OUT.clamp_raise_kick)
      else $error("clamp raise kick not a single pulse");

   c_field_written: cover property (WB_ACTIVE_OUT ##[1:1000] st.iflag[F_FEND]);
   c_lock_irq: cover property ($rose(LOCK_IN) ##[1:4] IRQ_OUT);
   c_flag_clear: cover property (st.iflag[4] ##1 !st.iflag[4]);
endmodule : vdb_top
`default_nettype wire

//--- include/vdb_pkg.sv
// Package for the video decoder back-end control block.
package vdb_pkg;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_YCS1   = 12'h040;
   localparam logic [ADDR_W-1:0] OFS_YCS2   = 12'h044;
   localparam logic [ADDR_W-1:0] OFS_ENH1   = 12'h050;
   localparam logic [ADDR_W-1:0] OFS_ENH2   = 12'h054;
   localparam logic [ADDR_W-1:0] OFS_CGAIN  = 12'h058;
   localparam logic [ADDR_W-1:0] OFS_WBCTL  = 12'h060;
   localparam logic [ADDR_W-1:0] OFS_WBGEO  = 12'h064;
   localparam logic [ADDR_W-1:0] OFS_YBASE  = 12'h068;
   localparam logic [ADDR_W-1:0] OFS_CBASE  = 12'h06c;
   localparam logic [ADDR_W-1:0] OFS_IEN    = 12'h080;
   localparam logic [ADDR_W-1:0] OFS_IFLAG  = 12'h090;
   localparam logic [ADDR_W-1:0] OFS_DBG    = 12'h100;
   localparam logic [31:0] RST_YCS1  = 32'h00004209;
   localparam logic [31:0] RST_YCS2  = 32'hff6440af;
   localparam logic [31:0] RST_ENH1  = 32'h14208000;
   localparam logic [31:0] RST_ENH2  = 32'h00000680;
   localparam logic [31:0] RST_CGAIN = 32'h00000000;
   localparam logic [31:0] RST_WBCTL = 32'h02d00020;
   localparam logic [31:0] RST_WBGEO = 32'h00f002d0;
   localparam logic [31:0] RST_ZERO  = 32'h00000000;
   localparam logic [31:0] RST_DBG   = 32'h00100000;
   localparam logic [31:0] MSK_YCS1  = 32'h3ff1ffff;
   localparam logic [31:0] MSK_ENH1  = 32'h3fffff0f;
   localparam logic [31:0] MSK_ENH2  = 32'h000007ff;
   localparam logic [31:0] MSK_CGAIN = 32'h1fff0fff;
   localparam logic [31:0] MSK_WBCTL = 32'h9fff017f;
   localparam logic [31:0] MSK_WBGEO = 32'h07ff0fff;
   localparam logic [31:0] MSK_IEN   = 32'hf10101fb;
   localparam logic [31:0] MSK_IFLAG = 32'hf10101b3;
   localparam logic [31:0] MSK_DBG   = 32'hffffff00;
   // Field positions.
   localparam int B_COMB_OFF = 3;
   localparam int B_SHARP_ON = 24;
   localparam int B_ORDER    = 31;
   localparam int B_FILT     = 28;
   localparam int B_VALID    = 8;
   localparam int B_FLIP     = 6;
   localparam int B_FRAME    = 5;
   localparam int B_TILED    = 4;
   localparam int B_FSEL     = 2;
   localparam int B_FMT      = 1;
   localparam int B_STORE    = 0;
   localparam int B_LOWER    = 24;
   localparam int B_RAISE    = 23;
   localparam int B_CLMODE   = 22;
   localparam int B_GMODE    = 21;
   localparam int F_LOCK     = 0;
   localparam int F_UNLOCK   = 1;
   localparam int F_BASEERR  = 16;
   localparam int F_FEND     = 24;
   localparam logic [8:0]  BRIGHT_ZERO = 9'h020;
   localparam int          UNITY_SHIFT = 7;
   localparam int          SKEW_DEPTH  = 8;
   typedef enum logic [1:0] {WB_IDLE, WB_WAIT, WB_LINES} vdb_wb_e;
   typedef struct packed {
      logic              valid;
      logic [7:0]        luma;
      logic signed [8:0] hipass;
      logic [7:0]        chroma;
   } vdb_pix_in_s;
   typedef struct packed {
      logic       valid;
      logic [7:0] luma;
      logic [7:0] chroma;
   } vdb_pix_out_s;
   typedef struct packed {
      logic       temporal_comb_active;
      logic [2:0] comb_separation_select;
      logic       chroma_order;
      logic       subsample_filter_on;
      logic       tiled_layout_select;
      logic       output_sampling_format;
      logic       clamp_auto;
      logic       clamp_raise_kick;
      logic       clamp_lower_kick;
      logic [6:0] clamp_step_cycles;
      logic [7:0] front_gain;
   } vdb_ctl_s;
endpackage : vdb_pkg

//--- sim/vdb_front_model.sv
// Stand-in for the decoder front end and capture timing around the block.
`timescale 1ns/10ps
`default_nettype none
module vdb_front_model
  (input  wire logic          clk_in,
   output logic               lock_out,
   output logic [7:0]         fault_out,
   output logic               fstart_out,
   output logic               fid_out,
   output logic               lend_out,
   output logic [7:0]         gain_out,
   output vdb_pkg::vdb_pix_in_s pix_out);
   import vdb_pkg::*;
   initial
   begin
      {lock_out, fault_out, fstart_out, lend_out} = '0;
      fid_out  = 1'b1;
      gain_out = 8'h33;
      pix_out  = '0;
   end
   // Pixels run every clock because the path has no handshake.
   always @(posedge clk_in)
      pix_out <= '{1'b1, pix_out.luma + 8'h01, 9'sh000, 8'h80};
   task automatic set_lock(input logic v);
      @(posedge clk_in) lock_out <= v;
   endtask : set_lock
   task automatic fault(input int i);
      @(posedge clk_in) fault_out <= 8'h01 << i;
      @(posedge clk_in) fault_out <= 8'h00;
   endtask : fault
   task automatic field(input logic id);
      @(posedge clk_in) {fstart_out, fid_out} <= {1'b1, id};
      @(posedge clk_in) {fstart_out, fid_out} <= {1'b0, ~id};
   endtask : field
   task automatic line();
      @(posedge clk_in) lend_out <= 1'b1;
      @(posedge clk_in) lend_out <= 1'b0;
   endtask : line
endmodule : vdb_front_model
`default_nettype wire

//--- sim/video_decoder_backend_control_tb.sv
// Self-checking bench for the video decoder back-end control block.
`timescale 1ns/10ps
`default_nettype none
module video_decoder_backend_control_tb;
   import vdb_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0, lock, fst, fid, lend;
   logic [1:0]  htrans = 2'b00;
   logic        hsel = 1'b1;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic [7:0]  fault, gain;
   logic        hready, hresp, wb_act, irq;
   logic [31:0] yaddr, caddr;
   logic [11:0] npix;
   vdb_pix_in_s  pix;
   vdb_pix_out_s pout;
   vdb_ctl_s     ctl;
   int          n_fail = 0, total_checks = 0;
   logic [11:0] ra[13] = '{OFS_YCS1, OFS_YCS2, OFS_ENH1, OFS_ENH2, OFS_CGAIN,
      OFS_WBCTL, OFS_WBGEO, OFS_YBASE, OFS_CBASE, OFS_IEN, OFS_IFLAG,
      OFS_DBG, 12'h0fc};
   logic [31:0] rv[13] = '{RST_YCS1, RST_YCS2, RST_ENH1, RST_ENH2, RST_CGAIN,
      RST_WBCTL, RST_WBGEO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
      RST_DBG, 32'h00000000};
   always #5 clk = ~clk;
   vdb_front_model FE (.clk_in(clk), .lock_out(lock), .fault_out(fault),
      .fstart_out(fst), .fid_out(fid), .lend_out(lend), .gain_out(gain),
      .pix_out(pix));
   vdb_top DUT (.CLK_SYS_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
      .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .PIX_IN(pix), .PIX_OUT(pout), .LOCK_IN(lock), .FIFO_FAULT_IN(fault),
      .AUTO_GAIN_IN(gain), .FIELD_START_IN(fst), .FIELD_ID_IN(fid),
      .LINE_END_IN(lend), .CTL_OUT(ctl), .WB_ACTIVE_OUT(wb_act),
      .WB_LUMA_ADDR_OUT(yaddr), .WB_CHROMA_ADDR_OUT(caddr),
      .WB_LINE_PIXELS_OUT(npix), .IRQ_OUT(irq));
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge clk) {htrans, hwrite, haddr} <= {2'b10, w, 20'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      {htrans, hwdata} <= {2'b00, d};
      do @(posedge clk); while (hready !== 1'b1);
      // Taken at the edge that ends the data phase, before the slave updates.
      q = hrdata;
   endtask : xfer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rchk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   task automatic end_of_test();
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   initial
   begin
      #50us;
      n_fail++;
      end_of_test();
   end
   initial
   begin
      idle(12);
      rst <= 1'b0;
      for (int i = 0; i < 13; i++) rchk(ra[i], rv[i]);
      idle(1);
      chk({24'h0, pout.luma}, {24'h0, 8'(pix.luma - 8'h01)});
      chk({23'h0, pout.valid, pout.chroma}, 32'h180);
      xfer(1'b1, OFS_ENH1, 32'h14208005);
      idle(1);
      chk({24'h0, pout.luma}, {24'h0, 8'(pix.luma - 8'h06)});
      xfer(1'b1, OFS_ENH1, RST_ENH1);
      xfer(1'b1, OFS_YCS1, 32'h00004201);
      idle(1);
      chk({28'h0, ctl.temporal_comb_active, ctl.comb_separation_select},
          32'h9);
      xfer(1'b1, OFS_YCS1, 32'h0000420c);
      idle(1);
      chk({28'h0, ctl.temporal_comb_active, ctl.comb_separation_select},
          32'h4);
      xfer(1'b1, OFS_IEN, 32'hffffffff);
      rchk(OFS_IEN, MSK_IEN);
      xfer(1'b1, OFS_IEN, 32'h00000001);
      FE.set_lock(1'b1);
      FE.fault(7);
      rchk(OFS_IFLAG, 32'h80000001);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, OFS_IFLAG, 32'h0);
      rchk(OFS_IFLAG, 32'h80000001);
      xfer(1'b1, OFS_IFLAG, 32'h80000000);
      FE.set_lock(1'b0);
      rchk(OFS_IFLAG, 32'h00000003);
      xfer(1'b1, OFS_IFLAG, 32'hffffffff);
      idle(1);
      chk({31'h0, irq}, 32'h0);
      chk({24'h0, ctl.front_gain}, 32'h33);
      xfer(1'b1, OFS_DBG, 32'h06605a00);
      idle(1);
      chk({16'h0, ctl.clamp_auto, ctl.clamp_step_cycles, ctl.front_gain},
          32'h035a);
      rchk(OFS_DBG, 32'h06605a00);
      xfer(1'b1, OFS_YBASE, 32'h10000000);
      xfer(1'b1, OFS_CBASE, 32'h20000000);
      xfer(1'b1, OFS_WBGEO, 32'h000202d0);
      xfer(1'b1, OFS_WBCTL, 32'h01000003);
      FE.field(1'b0);
      idle(3);
      chk({31'h0, wb_act}, 32'h0);
      xfer(1'b1, OFS_WBCTL, 32'h01000103);
      idle(2);
      FE.field(1'b1);
      idle(3);
      chk({31'h0, wb_act}, 32'h0);
      FE.field(1'b0);
      idle(2);
      chk({31'h0, wb_act}, 32'h1);
      chk(yaddr, 32'h10000000);
      chk(caddr, 32'h20000000);
      chk({20'h0, npix}, 32'h2d0);
      FE.line();
      idle(2);
      chk(yaddr, 32'h10000100);
      chk(caddr, 32'h20000100);
      xfer(1'b1, OFS_YBASE, 32'h10000000);
      FE.line();
      idle(2);
      chk({31'h0, wb_act}, 32'h0);
      rchk(OFS_IFLAG, 32'h01010000);
      xfer(1'b1, OFS_WBCTL, 32'h90000010);
      idle(1);
      chk({28'h0, ctl.chroma_order, ctl.subsample_filter_on,
           ctl.tiled_layout_select, ctl.output_sampling_format},
          32'he);
      end_of_test();
   end
endmodule : video_decoder_backend_control_tb
`default_nettype wire
